// ---- core/cgi_pkg.sv ----
// package of register map, field positions and reset values for the interrupt combiner
package cgi_pkg;
    // ------------------------------------------------------------
    // register indexes (printed offsets not all multiples of four)
    // ------------------------------------------------------------
    localparam logic [7:0] CGI_IDX_LIVE = 8'h0D;      // live source state
    localparam logic [7:0] CGI_IDX_MASK = 8'h0E;      // source mask
    localparam logic [7:0] CGI_IDX_POL = 8'h0F;       // edge polarity
    localparam logic [7:0] CGI_IDX_FLAG = 8'h10;      // edge flags
    localparam logic [7:0] CGI_IDX_CTRL = 8'h11;      // interrupt_control
    localparam logic [7:0] CGI_IDX_SEEN = 8'h13;      // sticky bus-side event status
    localparam logic [7:0] CGI_IDX_SEEN_MASK = 8'h14; // mask for bus interrupt
    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int CGI_BIT_EN = 0;                    // interrupt enable
    localparam int CGI_BIT_AND = 1;                   // combine select
    localparam int CGI_BIT_UNLOCK = 7;
    localparam int CGI_BIT_LOST = 6;
    localparam int CGI_BIT_CAL = 5;
    localparam int CGI_BIT_SWITCH = 1;
    localparam logic [7:0] CGI_SRC_BITS = 8'hE2;      // implemented source bits
    localparam logic [7:0] CGI_CTRL_BITS = 8'h03;     // implemented control bits
    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0] CGI_RST_CTRL = 8'h00;
    localparam logic [7:0] CGI_RST_MASK = 8'h00;
    localparam logic [7:0] CGI_RST_POL = 8'h00;
    localparam logic [7:0] CGI_RST_FLAG = 8'h00;
    // ------------------------------------------------------------
    // bus answers
    // ------------------------------------------------------------
    localparam logic [1:0] CGI_RESP_OKAY = 2'h0;
    localparam logic [1:0] CGI_RESP_SLVERR = 2'h2;
endpackage

// ---- core/cgi_src_if.sv ----
// interface carrying the source levels and edge strobes between combiner modules
`timescale 1ns/1ps
interface cgi_src_if;
    logic [7:0] level;   // present source levels
    logic [7:0] pol;     // edge polarity per source
    logic [7:0] edge_hit; // one-cycle strobe per source on a chosen edge
    modport det (input level, input pol, output edge_hit);
    modport top (output level, output pol, input edge_hit);
endinterface

// ---- core/cgi_edge_det.sv ----
// edge detector for the interrupt sources with per-source polarity
`timescale 1ns/1ps
module cgi_edge_det
    import cgi_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    cgi_src_if.det src
);
    logic [7:0] prev_r;
    logic [7:0] prev_nxt;
    logic [7:0] hit;

    // --------------------------------------------------------
    // edge selection
    // --------------------------------------------------------
    // rising edge when polarity is one, falling edge when zero
    always_comb
    begin
        prev_nxt = src.level;
        hit = (src.pol & src.level & ~prev_r)
            | (~src.pol & ~src.level & prev_r);
        src.edge_hit = hit & CGI_SRC_BITS;
    end

    // previous level, reset to zero so a source high out of reset is a rising edge
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            prev_r <= 8'h00;
        else
            prev_r <= prev_nxt;
    end
endmodule

// ---- core/cgi_axil_slave.sv ----
// AXI4-Lite slave front end: one write and one read, word registers by index
`timescale 1ns/1ps
module cgi_axil_slave
    import cgi_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [9:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [9:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic wr_stb,
    output logic [7:0] wr_idx,
    output logic [7:0] wr_data,
    output logic rd_stb,
    output logic [7:0] rd_idx,
    input wire logic [7:0] rd_data,
    input wire logic rd_ok,
    input wire logic wr_ok
);
    logic aw_have_r, aw_have_nxt, w_have_r, w_have_nxt;
    logic [7:0] aw_idx_r, aw_idx_nxt, w_data_r, w_data_nxt;
    logic bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt;
    logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic awready_r, awready_nxt, wready_r, wready_nxt, arready_r, arready_nxt;

    // --------------------------------------------------------
    // write path: address and data taken in either order
    // --------------------------------------------------------
    always_comb
    begin
        aw_have_nxt = aw_have_r;
        w_have_nxt = w_have_r;
        aw_idx_nxt = aw_idx_r;
        w_data_nxt = w_data_r;
        bvalid_nxt = bvalid_r;
        bresp_nxt = bresp_r;
        wr_stb = 1'b0;
        if (s_axi_awvalid && !aw_have_r && !bvalid_r)
        begin
            aw_have_nxt = 1'b1;
            aw_idx_nxt = s_axi_awaddr[9:2];
        end
        if (s_axi_wvalid && !w_have_r && !bvalid_r)
        begin
            w_have_nxt = 1'b1;
            w_data_nxt = s_axi_wstrb[0] ? s_axi_wdata[7:0] : 8'h00;
        end
        if (aw_have_r && w_have_r)
        begin
            wr_stb = s_axi_wstrb_ok();
            aw_have_nxt = 1'b0;
            w_have_nxt = 1'b0;
            bvalid_nxt = 1'b1;
            bresp_nxt = wr_ok ? CGI_RESP_OKAY : CGI_RESP_SLVERR;
        end
        else if (bvalid_r && s_axi_bready)
            bvalid_nxt = 1'b0;
        // readies registered so the bus sees them straight from flops
        awready_nxt = !aw_have_nxt && !bvalid_nxt;
        wready_nxt = !w_have_nxt && !bvalid_nxt;
    end

    // byte lane zero carries every register
    function automatic logic s_axi_wstrb_ok();
        return 1'b1;
    endfunction

    assign wr_idx = aw_idx_r;
    assign wr_data = w_data_r;
    assign s_axi_awready = awready_r;
    assign s_axi_wready = wready_r;

    // --------------------------------------------------------
    // read path: data returned one cycle after the address
    // --------------------------------------------------------
    always_comb
    begin
        rvalid_nxt = rvalid_r;
        rresp_nxt = rresp_r;
        rdata_nxt = rdata_r;
        rd_stb = 1'b0;
        if (s_axi_arvalid && !rvalid_r)
        begin
            rd_stb = 1'b1;
            rvalid_nxt = 1'b1;
            rdata_nxt = {24'h000000, rd_data};
            rresp_nxt = rd_ok ? CGI_RESP_OKAY : CGI_RESP_SLVERR;
        end
        else if (rvalid_r && s_axi_rready)
            rvalid_nxt = 1'b0;
        arready_nxt = !rvalid_nxt;
    end

    assign rd_idx = s_axi_araddr[9:2];
    assign s_axi_arready = arready_r;

    // registered bus state
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_have_r <= 1'b0;
            w_have_r <= 1'b0;
            aw_idx_r <= 8'h00;
            w_data_r <= 8'h00;
            bvalid_r <= 1'b0;
            bresp_r <= CGI_RESP_OKAY;
            rvalid_r <= 1'b0;
            rresp_r <= CGI_RESP_OKAY;
            rdata_r <= 32'h00000000;
            awready_r <= 1'b1;
            wready_r <= 1'b1;
            arready_r <= 1'b1;
        end
        else
        begin
            aw_have_r <= aw_have_nxt;
            w_have_r <= w_have_nxt;
            aw_idx_r <= aw_idx_nxt;
            w_data_r <= w_data_nxt;
            bvalid_r <= bvalid_nxt;
            bresp_r <= bresp_nxt;
            rvalid_r <= rvalid_nxt;
            rresp_r <= rresp_nxt;
            rdata_r <= rdata_nxt;
            awready_r <= awready_nxt;
            wready_r <= wready_nxt;
            arready_r <= arready_nxt;
        end
    end

    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rresp = rresp_r;
    assign s_axi_rdata = rdata_r;
endmodule

// ---- core/cgi_irq_combiner.sv ----
// top of the clock generator interrupt combiner with AXI4-Lite register access
`timescale 1ns/1ps
module cgi_irq_combiner
    import cgi_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [9:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [9:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic pll_unlocked,
    input wire logic ref_input_lost,
    input wire logic vco_cal_active,
    input wire logic backup_to_main_switch,
    output logic status_irq,
    output logic bus_irq
);
    // --------------------------------------------------------
    // declarations
    // --------------------------------------------------------
    logic [7:0] ctrl_r, ctrl_nxt;
    logic [7:0] mask_r, mask_nxt;
    logic [7:0] pol_r, pol_nxt;
    logic [7:0] flag_r, flag_nxt;
    logic [7:0] live_r, live_nxt;
    logic [7:0] seen_r, seen_nxt;
    logic [7:0] seen_mask_r, seen_mask_nxt;
    logic status_irq_r, status_irq_nxt;
    logic bus_irq_r, bus_irq_nxt;
    logic wr_stb, rd_stb;
    logic [7:0] wr_idx, wr_data, rd_idx;
    logic [7:0] rd_data;
    logic rd_ok, wr_ok;
    logic [7:0] live_src;
    logic [7:0] active;
    logic combined;
    logic prev_irq_r, prev_irq_nxt;

    cgi_src_if src_bus();

    // --------------------------------------------------------
    // bus slave and edge detector
    // --------------------------------------------------------
    cgi_axil_slave u_bus (
        .aclk(aclk),
        .aresetn(aresetn),
        .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready),
        .wr_stb(wr_stb),
        .wr_idx(wr_idx),
        .wr_data(wr_data),
        .rd_stb(rd_stb),
        .rd_idx(rd_idx),
        .rd_data(rd_data),
        .rd_ok(rd_ok),
        .wr_ok(wr_ok)
    );

    // source levels gathered into their register bit positions
    always_comb
    begin
        live_src = 8'h00;
        live_src[CGI_BIT_UNLOCK] = pll_unlocked;
        live_src[CGI_BIT_LOST] = ref_input_lost;
        live_src[CGI_BIT_CAL] = vco_cal_active;
        live_src[CGI_BIT_SWITCH] = backup_to_main_switch;
    end

    assign src_bus.level = live_src;
    assign src_bus.pol = pol_r;

    cgi_edge_det u_edge (
        .aclk(aclk),
        .aresetn(aresetn),
        .src(src_bus)
    );

    // --------------------------------------------------------
    // register read decode
    // --------------------------------------------------------
    always_comb
    begin
        rd_ok = 1'b1;
        case (rd_idx)
            CGI_IDX_CTRL: rd_data = ctrl_r;
            CGI_IDX_MASK: rd_data = mask_r;
            CGI_IDX_POL: rd_data = pol_r;
            CGI_IDX_FLAG: rd_data = flag_r;
            CGI_IDX_LIVE: rd_data = live_r;
            CGI_IDX_SEEN: rd_data = seen_r;
            CGI_IDX_SEEN_MASK: rd_data = seen_mask_r;
            default:
            begin
                rd_data = 8'h00;
                rd_ok = 1'b0;
            end
        endcase
    end

    // writes to the live register are ignored but answered as okay
    always_comb
    begin
        case (wr_idx)
            CGI_IDX_CTRL, CGI_IDX_MASK, CGI_IDX_POL, CGI_IDX_FLAG,
            CGI_IDX_LIVE, CGI_IDX_SEEN, CGI_IDX_SEEN_MASK: wr_ok = 1'b1;
            default: wr_ok = 1'b0;
        endcase
    end

    // --------------------------------------------------------
    // configuration and flag state
    // --------------------------------------------------------
    always_comb
    begin
        ctrl_nxt = ctrl_r;
        mask_nxt = mask_r;
        pol_nxt = pol_r;
        flag_nxt = flag_r;
        live_nxt = live_src;
        if (wr_stb)
        begin
            case (wr_idx)
                CGI_IDX_CTRL: ctrl_nxt = wr_data & CGI_CTRL_BITS;
                CGI_IDX_MASK: mask_nxt = wr_data & CGI_SRC_BITS;
                CGI_IDX_POL: pol_nxt = wr_data & CGI_SRC_BITS;
                CGI_IDX_FLAG: flag_nxt = flag_r & wr_data;
                default: ;
            endcase
        end
        // new edge wins over a clear in the same cycle, only while enabled
        if (ctrl_r[CGI_BIT_EN])
            flag_nxt = flag_nxt | src_bus.edge_hit;
    end

    // --------------------------------------------------------
    // combining of unmasked flags
    // --------------------------------------------------------
    always_comb
    begin
        active = flag_r & ~mask_r & CGI_SRC_BITS;
        if (ctrl_r[CGI_BIT_AND])
            combined = (active == (~mask_r & CGI_SRC_BITS))
                && (active != 8'h00);
        else
            combined = |active;
        status_irq_nxt = ctrl_r[CGI_BIT_EN] & combined;
        prev_irq_nxt = status_irq_r;
    end

    // --------------------------------------------------------
    // bus-side sticky status of flag rises and pin assertions
    // --------------------------------------------------------
    always_comb
    begin
        seen_nxt = seen_r;
        seen_mask_nxt = seen_mask_r;
        if (wr_stb && wr_idx == CGI_IDX_SEEN)
            seen_nxt = seen_r & ~wr_data;            // write one to clear
        if (wr_stb && wr_idx == CGI_IDX_SEEN_MASK)
            seen_mask_nxt = wr_data & CGI_SRC_BITS;
        // rising flags and pin rising edge are events; set wins over clear
        seen_nxt = seen_nxt | ((flag_nxt & ~flag_r) & CGI_SRC_BITS);
        seen_nxt[0] = seen_nxt[0] | (status_irq_r & ~prev_irq_r);
        bus_irq_nxt = |(seen_r & ~seen_mask_r);
    end

    // registered state
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ctrl_r <= CGI_RST_CTRL;
            mask_r <= CGI_RST_MASK;
            pol_r <= CGI_RST_POL;
            flag_r <= CGI_RST_FLAG;
            live_r <= 8'h00;
            seen_r <= 8'h00;
            seen_mask_r <= 8'h00;
            status_irq_r <= 1'b0;
            bus_irq_r <= 1'b0;
            prev_irq_r <= 1'b0;
        end
        else
        begin
            ctrl_r <= ctrl_nxt;
            mask_r <= mask_nxt;
            pol_r <= pol_nxt;
            flag_r <= flag_nxt;
            live_r <= live_nxt;
            seen_r <= seen_nxt;
            seen_mask_r <= seen_mask_nxt;
            status_irq_r <= status_irq_nxt;
            bus_irq_r <= bus_irq_nxt;
            prev_irq_r <= prev_irq_nxt;
        end
    end

    assign status_irq = status_irq_r;
    assign bus_irq = bus_irq_r;
endmodule

// ---- bench/cgi_host_model.sv ----
// host model that watches the status interrupt pin and counts its assertions
`timescale 1ns/1ps
module cgi_host_model
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic status_irq,
    output logic [7:0] irq_rises
);
    logic seen_r;
    // each new assertion of the pin counts as one interrupt taken by the host
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            seen_r <= 1'h0;
            irq_rises <= 8'h00;
        end
        else
        begin
            seen_r <= status_irq;
            if (status_irq && !seen_r)
                irq_rises <= irq_rises + 8'h01;
        end
    end
endmodule

// ---- bench/cgi_irq_combiner_props.sv ----
// checker of the interrupt combiner behaviour at its ports
`timescale 1ns/1ps
module cgi_irq_combiner_props
    import cgi_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [9:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic [9:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic pll_unlocked,
    input wire logic ref_input_lost,
    input wire logic vco_cal_active,
    input wire logic backup_to_main_switch,
    input wire logic status_irq
);
    // ------------------------------------------------------------
    // shadow of written settings, lagging the device by one cycle
    // ------------------------------------------------------------
    logic [7:0] aw_idx_r, wd_r, ar_idx_r, ctrl_r, mask_r, pol_r, src, last_r;
    logic [1:0] stab_r;
    logic bv_q, en, andm;
    assign src = {pll_unlocked, ref_input_lost, vco_cal_active, 3'h0, backup_to_main_switch, 1'h0};
    assign en = ctrl_r[0];
    assign andm = ctrl_r[1];
    // capture bus requests and apply a write when its answer shows
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ctrl_r <= 8'h00;
            mask_r <= 8'h00;
            pol_r <= 8'h00;
            bv_q <= 1'h0;
            stab_r <= 2'h0;
            last_r <= 8'h00;
        end
        else
        begin
            bv_q <= s_axi_bvalid;
            last_r <= src;
            stab_r <= (src != last_r) ? 2'h0 : ((stab_r == 2'h3) ? stab_r : stab_r + 2'h1);
            if (s_axi_awvalid && s_axi_awready)
                aw_idx_r <= s_axi_awaddr[9:2];
            if (s_axi_wvalid && s_axi_wready)
                wd_r <= s_axi_wdata[7:0];
            if (s_axi_arvalid && s_axi_arready)
                ar_idx_r <= s_axi_araddr[9:2];
            if (s_axi_bvalid && !bv_q && s_axi_bresp == CGI_RESP_OKAY)
            begin
                if (aw_idx_r == CGI_IDX_CTRL)
                    ctrl_r <= wd_r;
                if (aw_idx_r == CGI_IDX_MASK)
                    mask_r <= wd_r;
                if (aw_idx_r == CGI_IDX_POL)
                    pol_r <= wd_r;
            end
        end
    end
    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    property p_ctrl_read;
        $rose(s_axi_rvalid) && ar_idx_r == CGI_IDX_CTRL |-> s_axi_rdata == {30'h0, andm, en};
    endproperty
    a_ctrl_read: assert property (p_ctrl_read) else $error("control readback wrong");
    property p_live_read;
        $rose(s_axi_rvalid) && ar_idx_r == CGI_IDX_LIVE && stab_r == 2'h3 |-> s_axi_rdata == {24'h0, src};
    endproperty
    a_live_read: assert property (p_live_read) else $error("live readback wrong");
    property p_off_quiet;
        !en && $past(!en) |-> !status_irq;
    endproperty
    a_off_quiet: assert property (p_off_quiet) else $error("pin high while disabled");
    property p_masked_quiet;
        (mask_r & CGI_SRC_BITS) == CGI_SRC_BITS && $past(mask_r) == mask_r |-> !status_irq;
    endproperty
    a_masked_quiet: assert property (p_masked_quiet) else $error("pin high, all masked");
    property p_rise_sets;
        en && !andm && pol_r[7] && !mask_r[7] && $rose(pll_unlocked) |-> ##[1:4] status_irq;
    endproperty
    a_rise_sets: assert property (p_rise_sets) else $error("rise did not interrupt");
    property p_fall_sets;
        en && !andm && !pol_r[7] && !mask_r[7] && $fell(pll_unlocked) |-> ##[1:4] status_irq;
    endproperty
    a_fall_sets: assert property (p_fall_sets) else $error("fall did not interrupt");
    property p_and_single;
        en && andm && (mask_r & CGI_SRC_BITS) == 8'h62 && pol_r[7] && $rose(pll_unlocked)
            |-> ##[1:4] status_irq;
    endproperty
    a_and_single: assert property (p_and_single) else $error("and of one flag missed");
    property p_drop_by_write;
        $fell(status_irq) |-> $past(s_axi_bvalid) || $past(s_axi_bvalid, 2);
    endproperty
    a_drop_by_write: assert property (p_drop_by_write) else $error("pin fell unasked");
    c_and: cover property (en && andm && status_irq);
    c_off_edge: cover property (!en && $rose(pll_unlocked));
    c_live: cover property ($rose(s_axi_rvalid) && ar_idx_r == CGI_IDX_LIVE);
endmodule
bind cgi_irq_combiner cgi_irq_combiner_props u_props
(
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .pll_unlocked,
    .ref_input_lost, .vco_cal_active, .backup_to_main_switch, .status_irq
);

// ---- bench/tb_top.sv ----
// self-checking bench for the interrupt combiner
`timescale 1ns/1ps
module tb_top
    import cgi_pkg::*;
;
    logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic status_irq, bus_irq;
    logic [9:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [7:0] src, irq_rises;
    int failures = 0;
    int n_compared = 0;
    cgi_irq_combiner DUT
    (
        .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pll_unlocked(src[7]),
        .ref_input_lost(src[6]), .vco_cal_active(src[5]), .backup_to_main_switch(src[1]),
        .status_irq, .bus_irq
    );
    cgi_host_model host(.aclk, .aresetn, .status_irq, .irq_rises);
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            failures++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] idx, input logic [7:0] d, input logic [1:0] er = 2'h0);
        @(posedge aclk);
        s_axi_awaddr <= {idx, 2'h0};
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        do
        begin
            @(posedge aclk);
            if (s_axi_awready)
                s_axi_awvalid <= 1'h0;
            if (s_axi_wready)
                s_axi_wvalid <= 1'h0;
        end
        while (!s_axi_bvalid);
        s_axi_bready <= 1'h0;
        chk("bresp", {30'h0, s_axi_bresp}, {30'h0, er});
    endtask
    task automatic rd(input string nm, input logic [7:0] idx, input logic [7:0] exp,
        input logic [1:0] er = 2'h0);
        @(posedge aclk);
        s_axi_araddr <= {idx, 2'h0};
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do
        begin
            @(posedge aclk);
            if (s_axi_arready)
                s_axi_arvalid <= 1'h0;
        end
        while (!s_axi_rvalid);
        s_axi_rready <= 1'h0;
        chk(nm, {s_axi_rresp, s_axi_rdata[29:0]}, {er, 22'h0, exp});
    endtask
    task automatic drv(input logic [7:0] v);
        @(posedge aclk);
        src <= v;
        repeat (5) @(posedge aclk);
    endtask
    task automatic pin(input logic e);
        repeat (2) @(posedge aclk);
        chk("status_irq", {31'h0, status_irq}, {31'h0, e});
    endtask
    task automatic bus(input logic e);
        repeat (2) @(posedge aclk);
        chk("bus_irq", {31'h0, bus_irq}, {31'h0, e});
    endtask
    task automatic conclude();
        if (failures == 0 && n_compared > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        rd("ctrl", CGI_IDX_CTRL, 8'h00);
        rd("mask", CGI_IDX_MASK, 8'h00);
        rd("pol", CGI_IDX_POL, 8'h00);
        rd("flag", CGI_IDX_FLAG, 8'h00);
        rd("hole", 8'h3F, 8'h00, CGI_RESP_SLVERR);
        wr(8'h3F, 8'hFF, CGI_RESP_SLVERR);
    endtask
    task automatic t_disabled();
        drv(8'hE2);
        rd("live high", CGI_IDX_LIVE, 8'hE2);
        drv(8'h00);
        wr(CGI_IDX_LIVE, 8'hFF);
        rd("live low", CGI_IDX_LIVE, 8'h00);
        rd("flag frozen", CGI_IDX_FLAG, 8'h00);
        pin(1'h0);
        wr(CGI_IDX_CTRL, 8'h01);
        rd("flag after enable", CGI_IDX_FLAG, 8'h00);
        pin(1'h0);
    endtask
    task automatic t_edges();
        logic [7:0] bits [4] = '{8'h80, 8'h40, 8'h20, 8'h02};
        logic [7:0] m;
        logic [7:0] lv;
        for (int i = 0; i < 8; i++)
        begin
            m = bits[i / 2];
            lv = i[0] ? m : 8'h00;
            wr(CGI_IDX_POL, lv);
            drv(lv);
            wr(CGI_IDX_FLAG, 8'h00);
            drv(lv ^ m);
            rd("flag wrong edge", CGI_IDX_FLAG, 8'h00);
            pin(1'h0);
            drv(lv);
            rd("flag right edge", CGI_IDX_FLAG, m);
            pin(1'h1);
        end
        repeat (20) @(posedge aclk);
        wr(CGI_IDX_FLAG, 8'hFF);
        rd("flag kept", CGI_IDX_FLAG, 8'h02);
        pin(1'h1);
        wr(CGI_IDX_FLAG, 8'h00);
        rd("flag cleared", CGI_IDX_FLAG, 8'h00);
        pin(1'h0);
    endtask
    task automatic t_combine();
        logic [7:0] n0;
        wr(CGI_IDX_SEEN, 8'hFF);
        wr(CGI_IDX_SEEN_MASK, 8'hE2);
        wr(CGI_IDX_MASK, 8'hE2);
        wr(CGI_IDX_POL, 8'hE2);
        drv(8'h80);
        pin(1'h0);
        bus(1'h0);
        wr(CGI_IDX_SEEN_MASK, 8'h00);
        bus(1'h1);
        wr(CGI_IDX_SEEN, 8'hFF);
        bus(1'h0);
        wr(CGI_IDX_FLAG, 8'h00);
        wr(CGI_IDX_CTRL, 8'h03);
        rd("ctrl and", CGI_IDX_CTRL, 8'h03);
        wr(CGI_IDX_MASK, 8'h62);
        rd("mask", CGI_IDX_MASK, 8'h62);
        drv(8'h00);
        n0 = irq_rises;
        drv(8'h80);
        pin(1'h1);
        wr(CGI_IDX_MASK, 8'h22);
        pin(1'h0);
        drv(8'hC0);
        pin(1'h1);
        chk("host count", {24'h0, irq_rises - n0}, 32'h2);
        wr(CGI_IDX_CTRL, 8'h01);
        wr(CGI_IDX_MASK, 8'hE2);
        pin(1'h0);
        wr(CGI_IDX_MASK, 8'hA2);
        pin(1'h1);
        wr(CGI_IDX_CTRL, 8'h00);
        pin(1'h0);
        rd("ctrl cleared", CGI_IDX_CTRL, 8'h00);
    endtask
    // ------------------------------------------------------------
    // clock, watchdog and main sequence
    // ------------------------------------------------------------
    initial
    begin
        aclk = 1'h0;
        forever #2 aclk = ~aclk;
    end
    // cut a hang short well past the expected run length
    initial
    begin
        #200000;
        failures++;
        conclude();
    end
    // reset, then the scenarios in turn
    initial
    begin
        aresetn = 1'h0;
        s_axi_awvalid = 1'h0;
        s_axi_wvalid = 1'h0;
        s_axi_bready = 1'h0;
        s_axi_arvalid = 1'h0;
        s_axi_rready = 1'h0;
        s_axi_awaddr = 10'h000;
        s_axi_araddr = 10'h000;
        s_axi_wdata = 32'h0;
        src = 8'h00;
        repeat (10) @(posedge aclk);
        aresetn <= 1'h1;
        t_reset();
        t_disabled();
        t_edges();
        t_combine();
        conclude();
    end
endmodule
